/* bench/sepc_command_port_asserts.sv */
// Purpose: port assertions of the serial command port
// Assumes: the host holds each serial clock phase for at least four cycles
// Notes:   bound into the design from the bench top file
////////////////////////////////////////
module sepc_command_port_asserts
    import sepc_pkg::*;
#(
    parameter int WRITE_ALL_CYCLES = SEPC_WRITE_ALL_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chipSelect,
    input wire logic serialClock,
    input wire logic serialIn,
    input wire logic widthSelect,
    input wire logic programProtectPin,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BUSY_LIMIT = WRITE_ALL_CYCLES + 300;
    logic [31:0] lowCnt_q;
    logic        lowProt_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // length of each driven-low run, and whether protect stayed low through it
    always_ff @(posedge core_clk) begin
        if (srst || !(serialOutEn && !serialOut)) begin
            lowCnt_q  <= 32'h0;
            lowProt_q <= !programProtectPin;
        end else begin
            lowCnt_q  <= lowCnt_q + 32'h1;
            lowProt_q <= lowProt_q && !programProtectPin;
        end
    end
    AST_RESET_OFF: assert property (disable iff (1'b0) srst |=> !serialOutEn && !serialOut)
        else $error("output not off after reset");
    AST_DESELECT_OFF: assert property (!chipSelect [*6] |-> !serialOutEn)
        else $error("output driven while deselected");
    AST_DESELECT_DROP: assert property ($fell(chipSelect) |-> ##[1:6] !serialOutEn)
        else $error("output not released after deselect");
    AST_ENABLE_CAUSE: assert property ($rose(serialOutEn)
        |-> $past(serialClock, 3) && $past(chipSelect, 3)) else $error("enable without a rise");
    AST_FALL_CAUSE: assert property ($fell(serialOut) && serialOutEn && chipSelect
        |-> $past(serialClock, 3)) else $error("output fell without a serial rise");
    AST_ENABLE_STANDS: assert property ($rose(serialOutEn) |-> serialOutEn [*4])
        else $error("output enable pulse too short");
    AST_BUSY_BOUND: assert property (int'(lowCnt_q) <= BUSY_LIMIT)
        else $error("busy longer than the write-all limit");
    AST_PROTECT_QUIET: assert property (lowProt_q |-> lowCnt_q < 32'h20)
        else $error("busy shown while protected");
endmodule

/* bench/sepc_command_port_tb.sv */
// Purpose: self-checking bench of the serial command port
// Assumes: shortened self-timed counts; the host model drives the bus
// Notes:   array starts unknown, so an erase-all runs first
////////////////////////////////////////
module sepc_command_port_tb
    import sepc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WR_CYC = 20;
    localparam int EA_CYC = 2100;
    localparam int WA_CYC = 2200;
    logic core_clk          = 1'b0;
    logic srst              = 1'b1;
    logic widthSelect       = 1'b1;
    logic programProtectPin = 1'b1;
    logic chipSelect;
    logic serialClock;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    int   mismatches        = 0;
    int   compares          = 0;
    always #2 core_clk = ~core_clk;
    // device and host
    sepc_command_port #(.WRITE_CYCLES(WR_CYC), .ERASE_ALL_CYCLES(EA_CYC),
        .WRITE_ALL_CYCLES(WA_CYC)) i_sepc_command_port (.core_clk(core_clk), .srst(srst),
        .chipSelect(chipSelect), .serialClock(serialClock), .serialIn(serialIn),
        .widthSelect(widthSelect), .programProtectPin(programProtectPin),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    sepc_host_model i_sepc_host_model (.core_clk(core_clk), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .chipSelect(chipSelect), .serialClock(serialClock),
        .serialIn(serialIn));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // address and sub-command fields of the current width
    function automatic logic [10:0] fa(input logic [9:0] a);
        return widthSelect ? {2'b00, a[8:0]} : {1'b0, a};
    endfunction
    function automatic logic [10:0] fs(input logic [1:0] s);
        return widthSelect ? {1'b0, s, 8'h00} : {s, 9'h000};
    endfunction
    // idle zeros, start marker, opcode, field, then data bits if any
    task automatic frame(input logic [1:0] op, input logic [10:0] fld, input logic [15:0] d,
                         input int dn, output logic [31:0] r);
        i_sepc_host_model.shift(32'h0, 2, r);
        if (widthSelect) begin
            i_sepc_host_model.shift({19'h0, 1'b1, op, fld[9:0]}, 13, r);
        end else begin
            i_sepc_host_model.shift({18'h0, 1'b1, op, fld}, 14, r);
        end
        if (dn > 0) begin
            i_sepc_host_model.shift({16'h0, d}, dn, r);
        end
    endtask
    // programming frame: busy, then ready in time, then off after deselect
    task automatic prog(input logic [1:0] op, input logic [10:0] fld, input logic [15:0] d,
                        input int dn, input int lim);
        logic [31:0] r;
        int          w;
        frame(op, fld, d, dn, r);
        check({30'h0, serialOutEn, serialOut}, 32'h2);
        i_sepc_host_model.poll(lim + 40, w);
        check({31'h0, w <= lim + 8}, 32'h1);
        i_sepc_host_model.drop();
        check({31'h0, serialOutEn}, 32'h0);
    endtask
    // frame that must leave the output off
    task automatic quiet(input logic [1:0] op, input logic [10:0] fld, input int dn);
        logic [31:0] r;
        frame(op, fld, 16'h0000, dn, r);
        #160;
        check({31'h0, serialOutEn}, 32'h0);
        i_sepc_host_model.drop();
    endtask
    // read: dummy zero, then n bits running on through the following locations
    task automatic rd(input logic [9:0] a, input int n, input logic [31:0] exp);
        logic [31:0] r;
        frame(SEPC_OP_READ, fa(a), 16'h0000, 0, r);
        check({31'h0, r[0]}, 32'h0);
        i_sepc_host_model.shift(32'h0, n, r);
        check(r, exp);
        i_sepc_host_model.drop();
    endtask
    ////////////////////////////////////////
    task automatic t_program();
        quiet(SEPC_OP_WRITE, fa(10'h005), 16);
        quiet(2'h0, fs(SEPC_SUB_ENABLE), 0);
        prog(2'h0, fs(SEPC_SUB_ERALL), 16'h0000, 0, EA_CYC);
        prog(SEPC_OP_WRITE, fa(10'h005), 16'hA5C3, 16, WR_CYC);
        rd(10'h005, 32, 32'hA5C3_FFFF);
        $display("test program done");
    endtask
    task automatic t_bytes();
        widthSelect = 1'b0;
        rd(10'h00A, 32, 32'hA5C3_FFFF);
        prog(SEPC_OP_ERASE, fa(10'h00B), 16'h0000, 0, WR_CYC);
        rd(10'h009, 24, 32'h00FF_A5FF);
        prog(SEPC_OP_WRITE, fa(10'h3FF), 16'h005A, 8, WR_CYC);
        rd(10'h3FF, 16, 32'h0000_5AFF);
        $display("test bytes done");
    endtask
    task automatic t_protect();
        programProtectPin = 1'b0;
        quiet(SEPC_OP_WRITE, fa(10'h00A), 8);
        quiet(2'h0, fs(SEPC_SUB_ERALL), 0);
        rd(10'h00A, 8, 32'h0000_00A5);
        programProtectPin = 1'b1;
        $display("test protect done");
    endtask
    task automatic t_fill();
        widthSelect = 1'b1;
        quiet(2'h0, fs(SEPC_SUB_DIS), 0);
        quiet(SEPC_OP_WRITE, fa(10'h005), 16);
        rd(10'h005, 16, 32'h0000_A5FF);
        quiet(2'h0, fs(SEPC_SUB_ENABLE), 0);
        prog(2'h0, fs(SEPC_SUB_WRALL), 16'h1234, 16, WA_CYC);
        rd(10'h1FF, 32, 32'h1234_1234);
        prog(SEPC_OP_ERASE, fa(10'h1FF), 16'h0000, 0, WR_CYC);
        rd(10'h1FE, 32, 32'h1234_FFFF);
        $display("test fill done");
    endtask
    // reset in mid-run: outputs off, programming disabled, array kept
    task automatic t_reset();
        @(posedge core_clk);
        #1;
        srst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'b0;
        check({30'h0, serialOutEn, serialOut}, 32'h0);
        quiet(SEPC_OP_WRITE, fa(10'h1FE), 16);
        rd(10'h1FE, 16, 32'h0000_1234);
        $display("test reset done");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog: the tests need about 13,500 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        results();
    end
    // reset, then the scenarios in order
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        t_program();
        t_bytes();
        t_protect();
        t_fill();
        t_reset();
        results();
    end
endmodule

bind sepc_command_port sepc_command_port_asserts #(.WRITE_ALL_CYCLES(WRITE_ALL_CYCLES))
    i_sepc_command_port_asserts (.core_clk(core_clk), .srst(srst), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialIn(serialIn), .widthSelect(widthSelect),
    .programProtectPin(programProtectPin), .serialOut(serialOut), .serialOutEn(serialOutEn));

/* bench/sepc_host_model.sv */
// Purpose: host controller driving the three-wire serial bus
// Assumes: six core cycles in the high serial clock phase, seven in the low phase inside a frame
// Notes:   serial clock stands low between frames
////////////////////////////////////////
module sepc_host_model (
    input  wire logic core_clk,
    input  wire logic serialOut,
    input  wire logic serialOutEn,
    output logic      chipSelect,
    output logic      serialClock,
    output logic      serialIn
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 6;
    logic outPin;
    // a released output reads as the inverse of its last value
    assign outPin = serialOutEn ? serialOut : !serialOut;
    // idle bus at time zero
    initial begin
        chipSelect  = 1'b0;
        serialClock = 1'b0;
        serialIn    = 1'b0;
    end
    // n bits msb first; data set a half period before each rise, output taken late
    task automatic shift(input logic [31:0] v, input int n, output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            #1;
            chipSelect = 1'b1;
            serialIn   = v[i];
            repeat (HALF) @(posedge core_clk);
            #1;
            serialClock = 1'b1;
            repeat (HALF) @(posedge core_clk);
            #1;
            r           = {r[30:0], outPin};
            serialClock = 1'b0;
        end
    endtask
    // deselect; the data line no longer shows its last bit
    task automatic drop();
        @(posedge core_clk);
        #1;
        chipSelect = 1'b0;
        serialIn   = ~serialIn;
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    // keep select high and poll until ready shows or the limit runs out
    task automatic poll(input int limit, output int waited);
        waited = 0;
        while (!(serialOutEn === 1'b1 && serialOut === 1'b1) && waited < limit) begin
            @(posedge core_clk);
            #1;
            waited++;
        end
    endtask
endmodule

/* inc/sepc_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Purpose: constants and types of the serial eeprom command port
// Assumes: core clock of 250 MHz, times kept in microseconds
// Notes:   all opcodes, lengths and cycle counts live here
////////////////////////////////////////////////////////////////////////////////
package sepc_pkg;

    // clock rate and self-timed cycle limits
    localparam int SEPC_CLK_MHZ           = 250;
    localparam int SEPC_WRITE_TIME_US     = 10000;
    localparam int SEPC_ERASE_ALL_TIME_US = 15000;
    localparam int SEPC_WRITE_ALL_TIME_US = 30000;
    localparam int SEPC_WRITE_CYCLES      = SEPC_WRITE_TIME_US * SEPC_CLK_MHZ;
    localparam int SEPC_ERASE_ALL_CYCLES  = SEPC_ERASE_ALL_TIME_US * SEPC_CLK_MHZ;
    localparam int SEPC_WRITE_ALL_CYCLES  = SEPC_WRITE_ALL_TIME_US * SEPC_CLK_MHZ;

    // array geometry: 1024 bytes, or 512 words of two bytes
    localparam int         SEPC_BYTES     = 1024;
    localparam int         SEPC_WORDS     = 512;
    localparam logic [9:0] SEPC_LAST_BYTE = 10'h3FF;
    localparam logic [9:0] SEPC_WORD_STEP = 10'h002;
    localparam logic [9:0] SEPC_BYTE_STEP = 10'h001;
    localparam logic [9:0] SEPC_ODD_BYTE  = 10'h001;
    localparam logic [9:0] SEPC_ZERO_ADDR = 10'h000;

    // field lengths after the start marker: opcode plus address field, then data
    localparam logic [4:0] SEPC_HDR_X16  = 5'h0C;
    localparam logic [4:0] SEPC_HDR_X8   = 5'h0D;
    localparam logic [4:0] SEPC_DLEN_X16 = 5'h10;
    localparam logic [4:0] SEPC_DLEN_X8  = 5'h08;
    localparam logic [4:0] SEPC_ONE      = 5'h01;

    // opcodes and special sub-commands
    localparam logic [1:0] SEPC_OP_READ    = 2'h2;
    localparam logic [1:0] SEPC_OP_WRITE   = 2'h1;
    localparam logic [1:0] SEPC_OP_ERASE   = 2'h3;
    localparam logic [1:0] SEPC_SUB_ENABLE = 2'h3;
    localparam logic [1:0] SEPC_SUB_ERALL  = 2'h2;
    localparam logic [1:0] SEPC_SUB_WRALL  = 2'h1;
    localparam logic [1:0] SEPC_SUB_DIS    = 2'h0;

    // erased cell value and protecting level of the protect pin
    localparam logic [7:0] SEPC_ERASED        = 8'hFF;
    localparam logic [7:0] SEPC_PAD           = 8'h00;
    localparam logic       SEPC_PROTECT_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        SEPC_JOB_ERASE, SEPC_JOB_WRITE, SEPC_JOB_ERASE_ALL, SEPC_JOB_WRITE_ALL
    } sepc_job_kind_t;

    // one self-timed programming job
    typedef struct packed {
        sepc_job_kind_t kind;
        logic           wide;
        logic [9:0]     addr;
        logic [15:0]    data;
    } sepc_job_t;

    typedef enum logic [1:0] {SEPC_IDLE, SEPC_HDR, SEPC_DATA, SEPC_READ} sepc_state_t;

endpackage

/* verilog/sepc_command_port.sv */
////////////////////////////////////////////////////////////////////////////////
// Purpose: three-wire serial command port of a 1024 x 8 / 512 x 16 eeprom
// Assumes: pins are asynchronous to core_clk and pass two flip-flops first
// Notes:   serial clock edges are found by sampling, not used as a clock
////////////////////////////////////////////////////////////////////////////////
module sepc_command_port
    import sepc_pkg::*;
#(
    parameter int WRITE_CYCLES     = SEPC_WRITE_CYCLES,
    parameter int ERASE_ALL_CYCLES = SEPC_ERASE_ALL_CYCLES,
    parameter int WRITE_ALL_CYCLES = SEPC_WRITE_ALL_CYCLES,
    parameter int FIFO_DEPTH       = 2
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic chipSelect,
    input  wire logic serialClock,
    input  wire logic serialIn,
    input  wire logic widthSelect,
    input  wire logic programProtectPin,
    output logic      serialOut,
    output logic      serialOutEn
);

    localparam int TW = $clog2(WRITE_ALL_CYCLES + 1);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // refuse settings the sweep, timer or buffer pointers cannot serve
    if (WRITE_CYCLES < 4 || ERASE_ALL_CYCLES < 2 * SEPC_BYTES + 2
        || WRITE_ALL_CYCLES < ERASE_ALL_CYCLES || WRITE_ALL_CYCLES < WRITE_CYCLES
        || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_check
        $error("sepc_command_port: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [4:0]         pinMeta_q, pinSync_q;
    logic               sclkPrev_q;
    logic               csS, sclkS, diS, wideS, protS, rise;
    logic [7:0]         mem [SEPC_BYTES];
    sepc_state_t        state_q, state_d;
    logic [12:0]        hdr_q, hdr_d, hdrNext;
    logic [15:0]        dataSh_q, dataSh_d, dataNext;
    logic [4:0]         cnt_q, cnt_d, hdrLen, dataLen;
    sepc_job_t          job_q, job_d;
    logic               progEn_q, progEn_d, busy_q, busy_d, pass_q, pass_d;
    logic               writing_q, writing_d, statusShow_q, statusShow_d;
    logic [9:0]         sweep_q, sweep_d, readAddr_q, readAddr_d, hdrAddr;
    logic [TW-1:0]      timer_q, timer_d;
    logic [15:0]        outWord_q, outWord_d;
    logic [4:0]         outCnt_q, outCnt_d;
    logic               readBit_q, readBit_d, outBit_q, outBit_d, outEn_q, outEn_d;
    logic [1:0]         opc, sub;
    logic               launch, pop, push, single, memWeA, memWeB;
    logic [7:0]         memValA, memValB;
    logic [15:0]        fifoMem [FIFO_DEPTH];
    logic [15:0]        pushWord, fifoHead;
    logic [PW-1:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [CW-1:0]      count_q, count_d;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: cs, sclk, data in, width select, protect
    assign csS   = pinSync_q[0];
    assign sclkS = pinSync_q[1];
    assign diS   = pinSync_q[2];
    assign wideS = pinSync_q[3];
    assign protS = pinSync_q[4];
    assign rise  = sclkS & ~sclkPrev_q;

    // frame geometry from the width select
    assign hdrLen   = wideS ? SEPC_HDR_X16 : SEPC_HDR_X8;
    assign dataLen  = wideS ? SEPC_DLEN_X16 : SEPC_DLEN_X8;
    assign hdrNext  = {hdr_q[11:0], diS};
    assign dataNext = {dataSh_q[14:0], diS};
    assign opc      = wideS ? hdrNext[11:10] : hdrNext[12:11];
    assign sub      = wideS ? hdrNext[9:8] : hdrNext[10:9];
    assign hdrAddr  = wideS ? {hdrNext[8:0], 1'b0} : hdrNext[9:0];
    assign single   = (job_q.kind == SEPC_JOB_ERASE) || (job_q.kind == SEPC_JOB_WRITE);

    // read buffer: prefetch while in a read, drained by the shifter
    assign fifoHead = fifoMem[rdPtr_q];
    assign push     = (state_q == SEPC_READ) && (count_q != CW'(FIFO_DEPTH));
    assign pushWord = wideS ? {mem[readAddr_q], mem[readAddr_q | SEPC_ODD_BYTE]}
                            : {mem[readAddr_q], SEPC_PAD};

    ////////////////////////////////////////////////////////////////////////////
    // next state of the frame decoder and programming engine
    always_comb begin
        state_d = state_q;   hdr_d = hdr_q;     dataSh_d = dataSh_q;  cnt_d = cnt_q;
        job_d = job_q;       progEn_d = progEn_q; busy_d = busy_q;   pass_d = pass_q;
        writing_d = writing_q; statusShow_d = statusShow_q; sweep_d = sweep_q;
        timer_d = timer_q;   readAddr_d = readAddr_q; outWord_d = outWord_q;
        outCnt_d = outCnt_q; readBit_d = readBit_q;
        launch = 1'b0;       pop = 1'b0;        memWeA = 1'b0;        memWeB = 1'b0;
        memValA = SEPC_ERASED;
        memValB = SEPC_ERASED;
        if (push) begin
            readAddr_d = readAddr_q + (wideS ? SEPC_WORD_STEP : SEPC_BYTE_STEP);
        end
        // self-timed job: erase pass, then program pass for write jobs, then wait out the timer
        if (busy_q) begin
            timer_d = (timer_q == '0) ? '0 : timer_q - TW'(1);
            if (writing_q) begin
                memWeA  = 1'b1;
                memWeB  = single && job_q.wide;
                memValA = !pass_q ? SEPC_ERASED : (!single && job_q.wide && sweep_q[0])
                          ? job_q.data[7:0] : job_q.data[15:8];
                memValB = pass_q && job_q.kind == SEPC_JOB_WRITE ? job_q.data[7:0]
                                                                 : SEPC_ERASED;
                if (single || sweep_q == SEPC_LAST_BYTE) begin
                    sweep_d   = single ? job_q.addr : SEPC_ZERO_ADDR;
                    pass_d    = 1'b1;
                    writing_d = !pass_q && (job_q.kind == SEPC_JOB_WRITE
                                || job_q.kind == SEPC_JOB_WRITE_ALL);
                end else begin
                    sweep_d = sweep_q + SEPC_BYTE_STEP;
                end
            end else if (timer_q == '0) begin
                busy_d = 1'b0;
            end
        end
        // serial frame decoder
        if (!csS) begin
            state_d      = SEPC_IDLE;
            statusShow_d = 1'b0;
        end else if (rise) begin
            case (state_q)
                SEPC_IDLE: begin
                    if (diS && !busy_q) begin
                        state_d      = SEPC_HDR;
                        cnt_d        = '0;
                        statusShow_d = 1'b0;
                    end
                end
                SEPC_HDR: begin
                    hdr_d = hdrNext;
                    cnt_d = cnt_q + SEPC_ONE;
                    if (cnt_q == hdrLen - SEPC_ONE) begin
                        state_d     = SEPC_IDLE;
                        cnt_d       = '0;
                        job_d.addr  = hdrAddr;
                        job_d.wide  = wideS;
                        case (opc)
                            SEPC_OP_READ: begin
                                state_d    = SEPC_READ;
                                readAddr_d = hdrAddr;
                                readBit_d  = 1'b0;                   // leading dummy zero
                                outCnt_d   = '0;
                            end
                            SEPC_OP_WRITE: begin
                                job_d.kind = SEPC_JOB_WRITE;
                                state_d    = SEPC_DATA;
                            end
                            SEPC_OP_ERASE: begin
                                job_d.kind = SEPC_JOB_ERASE;
                                launch     = 1'b1;
                            end
                            default: begin
                                case (sub)
                                    SEPC_SUB_ENABLE: progEn_d = 1'b1;
                                    SEPC_SUB_DIS:    progEn_d = 1'b0;
                                    SEPC_SUB_ERALL: begin
                                        job_d.kind = SEPC_JOB_ERASE_ALL;
                                        launch     = 1'b1;
                                    end
                                    default: begin
                                        job_d.kind = SEPC_JOB_WRITE_ALL;
                                        state_d    = SEPC_DATA;
                                    end
                                endcase
                            end
                        endcase
                    end
                end
                SEPC_DATA: begin
                    dataSh_d = dataNext;
                    cnt_d    = cnt_q + SEPC_ONE;
                    if (cnt_q == dataLen - SEPC_ONE) begin
                        state_d = SEPC_IDLE;
                        launch  = 1'b1;
                    end
                end
                SEPC_READ: begin
                    if (outCnt_q == '0) begin
                        if (count_q != '0) begin
                            pop       = 1'b1;
                            readBit_d = fifoHead[15];
                            outWord_d = {fifoHead[14:0], 1'b0};
                            outCnt_d  = dataLen - SEPC_ONE;
                        end
                    end else begin
                        readBit_d = outWord_q[15];
                        outWord_d = {outWord_q[14:0], 1'b0};
                        outCnt_d  = outCnt_q - SEPC_ONE;
                    end
                end
                default: state_d = SEPC_IDLE;
            endcase
        end
        // start a self-timed cycle only when enabled and not protected
        if (launch && progEn_q && protS != SEPC_PROTECT_LEVEL) begin
            job_d.data   = wideS ? dataNext : {dataNext[7:0], SEPC_PAD};
            busy_d       = 1'b1;
            writing_d    = 1'b1;
            pass_d       = 1'b0;
            sweep_d      = (job_d.kind == SEPC_JOB_ERASE || job_d.kind == SEPC_JOB_WRITE)
                           ? job_d.addr : SEPC_ZERO_ADDR;
            timer_d      = (job_d.kind == SEPC_JOB_ERASE_ALL) ? TW'(ERASE_ALL_CYCLES - 1)
                         : (job_d.kind == SEPC_JOB_WRITE_ALL) ? TW'(WRITE_ALL_CYCLES - 1)
                         : TW'(WRITE_CYCLES - 1);
            statusShow_d = 1'b1;
        end
    end

    // next values of the read buffer; flushed whenever the read ends
    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (state_q != SEPC_READ) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            count_d = '0;
        end else begin
            wrPtr_d = push ? wrPtr_q + PW'(1) : wrPtr_q;
            rdPtr_d = pop ? rdPtr_q + PW'(1) : rdPtr_q;
            count_d = count_q + CW'(push) - CW'(pop);
        end
    end

    // output pin: read data, or ready/busy status, released when cs is low
    always_comb begin
        outEn_d  = csS && (state_d == SEPC_READ || statusShow_d);
        outBit_d = statusShow_d ? !busy_d : readBit_d;
    end

    assign serialOut   = outBit_q;
    assign serialOutEn = outEn_q;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk) begin
        pinMeta_q  <= {programProtectPin, widthSelect, serialIn, serialClock, chipSelect};
        pinSync_q  <= pinMeta_q;
        sclkPrev_q <= pinSync_q[1];
        if (srst) begin
            state_q  <= SEPC_IDLE;  hdr_q     <= '0;   dataSh_q <= '0;  cnt_q <= '0;
            job_q    <= '0;         progEn_q  <= 1'b0; busy_q   <= 1'b0; pass_q <= 1'b0;
            writing_q <= 1'b0;      statusShow_q <= 1'b0; sweep_q <= '0; timer_q <= '0;
            readAddr_q <= '0;       outWord_q <= '0;   outCnt_q <= '0;  readBit_q <= 1'b0;
            outBit_q <= 1'b0;       outEn_q   <= 1'b0;
            wrPtr_q  <= '0;         rdPtr_q   <= '0;   count_q  <= '0;
        end else begin
            state_q  <= state_d;    hdr_q     <= hdr_d;   dataSh_q <= dataSh_d;
            cnt_q    <= cnt_d;      job_q     <= job_d;   progEn_q <= progEn_d;
            busy_q   <= busy_d;     pass_q    <= pass_d;  writing_q <= writing_d;
            statusShow_q <= statusShow_d; sweep_q <= sweep_d; timer_q <= timer_d;
            readAddr_q <= readAddr_d; outWord_q <= outWord_d; outCnt_q <= outCnt_d;
            readBit_q <= readBit_d; outBit_q  <= outBit_d; outEn_q  <= outEn_d;
            wrPtr_q  <= wrPtr_d;    rdPtr_q   <= rdPtr_d; count_q  <= count_d;
        end
    end

    // array and buffer storage, not reset (contents survive reset)
    always_ff @(posedge core_clk) begin
        if (memWeA) begin
            mem[sweep_q] <= memValA;
        end
        if (memWeB) begin
            mem[sweep_q | SEPC_ODD_BYTE] <= memValB;
        end
        if (push) begin
            fifoMem[wrPtr_q] <= pushWord;
        end
    end

endmodule
